// ==== hw/sac_pkg.sv ====
package sac_pkg;

  // cpu addresses of the two registers
  localparam logic [15:0] SAC_MODE_ADDR   = 16'hff80;
  localparam logic [15:0] SAC_RESULT_ADDR = 16'hff81;

  // mode register reset value and field positions
  localparam logic [7:0] SAC_MODE_RST = 8'h01;
  localparam int unsigned SAC_RUN_POS = 7;
  localparam int unsigned SAC_TRIG_POS = 6;
  localparam int unsigned SAC_TSEL_HI_POS = 5;
  localparam int unsigned SAC_TSEL_LO_POS = 4;
  localparam int unsigned SAC_CH_MSB  = 3;
  localparam int unsigned SAC_CH_LSB  = 1;
  localparam int unsigned SAC_HSPEED_POS = 0;

  // time-select codes {time hi, time lo, high speed}
  localparam logic [2:0] SAC_TS_001 = 3'h1;
  localparam logic [2:0] SAC_TS_011 = 3'h3;
  localparam logic [2:0] SAC_TS_100 = 3'h4;
  localparam logic [2:0] SAC_TS_101 = 3'h5;

  // conversion lengths in oscillator periods, {undivided, divided}
  localparam logic [7:0] SAC_P_001_UNDIV = 8'h50;  // 80
  localparam logic [7:0] SAC_P_001_DIV   = 8'ha0;  // 160
  localparam logic [7:0] SAC_P_011_UNDIV = 8'h28;  // 40
  localparam logic [7:0] SAC_P_011_DIV   = 8'h50;  // 80
  localparam logic [7:0] SAC_P_100_UNDIV = 8'h32;  // 50
  localparam logic [7:0] SAC_P_100_DIV   = 8'h64;  // 100
  localparam logic [7:0] SAC_P_101_UNDIV = 8'h64;  // 100
  localparam logic [7:0] SAC_P_101_DIV   = 8'hc8;  // 200

  // a conversion is 2 sample steps plus 8 compare steps
  localparam logic [7:0] SAC_STEPS_TOTAL  = 8'h0a;
  localparam logic [7:0] SAC_SAMPLE_STEPS = 8'h02;
  localparam logic [2:0] SAC_MSB_IDX      = 3'h7;
  // clock cycles per oscillator period (i_clk stands in for the oscillator)
  localparam logic [7:0] SAC_CLKS_PER_FX  = 8'h01;

  typedef enum logic [1:0] {
    SAC_IDLE,
    SAC_ARMED,
    SAC_SAMPLE,
    SAC_CONVERT
  } sac_state_t;

  // cpu access request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        bit_wr;
    logic [2:0]  bit_sel;
    logic        bit_val;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } sac_cpu_req_t;

  // drive toward sample-hold, ladder tap and channel mux
  typedef struct packed {
    logic       hold;
    logic [2:0] channel;
    logic [7:0] tap_code;
  } sac_analog_t;

  // cycles of one step (a tenth of the conversion) for a code and clock setting
  function automatic logic [7:0] sac_step_cycles(input logic [2:0] code, input logic undiv);
    logic [7:0] periods;
    periods = SAC_P_101_DIV;
    case (code)
      SAC_TS_001: periods = undiv ? SAC_P_001_UNDIV : SAC_P_001_DIV;
      SAC_TS_011: periods = undiv ? SAC_P_011_UNDIV : SAC_P_011_DIV;
      SAC_TS_100: periods = undiv ? SAC_P_100_UNDIV : SAC_P_100_DIV;
      SAC_TS_101: periods = undiv ? SAC_P_101_UNDIV : SAC_P_101_DIV;
      default:    periods = SAC_P_101_DIV;
    endcase
    sac_step_cycles = 8'((16'(periods) * 16'(SAC_CLKS_PER_FX)) / 16'(SAC_STEPS_TOTAL));
  endfunction

endpackage

// ==== hw/sac_sync2.sv ====
`timescale 1ns/1ps

// two-flop level synchroniser for one pin
module sac_sync2 (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  // pin level in, synchronised level out
  input  wire logic i_async,
  output logic      o_sync
);

  logic meta_r;

  // first flop feeds only the second
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      meta_r <= 1'b0;
      o_sync <= 1'b0;
    end
    else
    begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule

// ==== hw/sac_adc_ctrl.sv ====
`timescale 1ns/1ps

module sac_adc_ctrl (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_arst_n,
  // cpu register port
  input  wire sac_pkg::sac_cpu_req_t i_cpu,
  output logic [7:0]                 o_cpu_rdata,
  // clock divider setting, analog pin selection (same clock domain)
  input  wire logic                  i_main_clock_div_select,
  input  wire logic [7:0]            i_analog_pin_select,
  // pins: comparator result and external trigger
  input  wire logic                  i_comparator,
  input  wire logic                  i_ext_trigger_input,
  // analog side
  output sac_pkg::sac_analog_t       o_analog,
  // digital port enables, completion pulse, result value
  output logic [7:0]                 o_port_digital_en,
  output logic                       o_conversion_done_irq,
  output logic [7:0]                 o_conversion_result
);
  import sac_pkg::*;

  // controller state except the result register
  typedef struct packed {
    sac_state_t state;
    logic [7:0] mode;
    logic [7:0] approx;
    logic [2:0] bit_idx;
    logic [7:0] step_cnt;
    logic [7:0] sample_cnt;
    logic       done;
    logic       trig_prev;
    logic [7:0] rdata;
  } sac_ctrl_t;

  sac_ctrl_t  st_r;
  sac_ctrl_t  st_nxt;
  logic [7:0] result_r;
  logic       comp_sync;
  logic       trig_sync;

  // pin synchronisers
  sac_sync2 u_sync_comp (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_async  (i_comparator),
    .o_sync   (comp_sync)
  );

  sac_sync2 u_sync_trig (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_async  (i_ext_trigger_input),
    .o_sync   (trig_sync)
  );

  // decoded mode fields, trigger edge, step end, comparator and write decode
  logic       run_en;
  logic       hw_trigger_select;
  logic [2:0] time_code;
  logic [7:0] step_len;
  logic       trig_edge;
  logic       mode_hit;
  logic       mode_wr;
  logic [7:0] mode_wval;
  logic       cmp_keep;
  logic       step_end;

  // field extraction, step length, trigger edge, step end and comparator
  assign run_en            = st_r.mode[SAC_RUN_POS];
  assign hw_trigger_select = st_r.mode[SAC_TRIG_POS];
  assign time_code         = {st_r.mode[SAC_TSEL_HI_POS], st_r.mode[SAC_TSEL_LO_POS], st_r.mode[SAC_HSPEED_POS]};
  assign step_len          = sac_step_cycles(time_code, i_main_clock_div_select);
  assign trig_edge         = trig_sync & ~st_r.trig_prev;
  assign step_end          = (st_r.step_cnt == (step_len - 8'h01));
  assign cmp_keep          = comp_sync;

  // mode register write decode, byte or single bit
  assign mode_hit = (i_cpu.addr == SAC_MODE_ADDR);
  assign mode_wr  = mode_hit & (i_cpu.wr | i_cpu.bit_wr);
  always_comb
  begin
    mode_wval = st_r.mode;
    if (i_cpu.wr)
      mode_wval = i_cpu.wdata;
    else if (i_cpu.bit_wr)
      mode_wval[i_cpu.bit_sel] = i_cpu.bit_val;
  end

  // next-state logic
  always_comb
  begin
    st_nxt           = st_r;
    st_nxt.done      = 1'b0;
    st_nxt.trig_prev = trig_sync;

    // read data, result readable as a whole byte only
    if (i_cpu.rd)
    begin
      if (i_cpu.addr == SAC_MODE_ADDR)
        st_nxt.rdata = st_r.mode;
      else if (i_cpu.addr == SAC_RESULT_ADDR)
        st_nxt.rdata = result_r;
      else
        st_nxt.rdata = 8'h00;
    end

    case (st_r.state)
      SAC_IDLE:
      begin
        st_nxt.state = SAC_IDLE;
      end
      SAC_ARMED:
      begin
        // one trigger, one conversion
        if (trig_edge)
        begin
          st_nxt.state      = SAC_SAMPLE;
          st_nxt.sample_cnt = 8'h00;
          st_nxt.step_cnt   = 8'h00;
        end
      end
      SAC_SAMPLE:
      begin
        // sample-hold tracks the input for two steps
        if (step_end)
        begin
          st_nxt.step_cnt = 8'h00;
          if (st_r.sample_cnt == (SAC_SAMPLE_STEPS - 8'h01))
          begin
            st_nxt.state   = SAC_CONVERT;
            st_nxt.bit_idx = SAC_MSB_IDX;
            st_nxt.approx  = 8'h00;
          end
          else
            st_nxt.sample_cnt = st_r.sample_cnt + 8'h01;
        end
        else
          st_nxt.step_cnt = st_r.step_cnt + 8'h01;
      end
      SAC_CONVERT:
      begin
        // one compare per step, msb first
        if (step_end)
        begin
          st_nxt.step_cnt             = 8'h00;
          st_nxt.approx[st_r.bit_idx] = cmp_keep;
          if (st_r.bit_idx == 3'h0)
          begin
            st_nxt.done       = 1'b1;
            st_nxt.sample_cnt = 8'h00;
            if (hw_trigger_select)
              st_nxt.state = SAC_ARMED;
            else
              st_nxt.state = SAC_SAMPLE;
          end
          else
            st_nxt.bit_idx = st_r.bit_idx - 3'h1;
        end
        else
          st_nxt.step_cnt = st_r.step_cnt + 8'h01;
      end
      default:
      begin
        st_nxt.state = SAC_IDLE;
      end
    endcase

    // mode write aborts whatever runs and applies the new settings
    if (mode_wr)
    begin
      st_nxt.mode       = mode_wval;
      st_nxt.done       = 1'b0;
      st_nxt.step_cnt   = 8'h00;
      st_nxt.sample_cnt = 8'h00;
      if (!mode_wval[SAC_RUN_POS])
        st_nxt.state = SAC_IDLE;
      else if (mode_wval[SAC_TRIG_POS])
        st_nxt.state = SAC_ARMED;
      else
        st_nxt.state = SAC_SAMPLE;
    end
    else if (!run_en)
      st_nxt.state = SAC_IDLE;
  end

  // state register
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_r           <= '0;
      st_r.state     <= SAC_IDLE;
      st_r.mode      <= SAC_MODE_RST;
    end
    else
      st_r <= st_nxt;
  end

  // result register, no reset, loaded only at conversion end
  always_ff @(posedge i_clk)
  begin
    if (st_nxt.done)
      result_r <= st_nxt.approx;
  end

  // analog drive: hold while comparing, trial bit on ladder tap
  always_comb
  begin
    o_analog.hold     = (st_r.state == SAC_CONVERT);
    o_analog.channel  = st_r.mode[SAC_CH_MSB:SAC_CH_LSB];
    o_analog.tap_code = st_r.approx;
    if (st_r.state == SAC_CONVERT)
      o_analog.tap_code[st_r.bit_idx] = 1'b1;
  end

  // outputs
  assign o_port_digital_en     = ~i_analog_pin_select;
  assign o_conversion_done_irq = st_r.done;
  assign o_conversion_result   = result_r;
  assign o_cpu_rdata           = st_r.rdata;

endmodule

// ==== sim/sac_adc_ctrl_props.sv ====
`timescale 1ns/1ps

// port-level checks of the converter control block
module sac_adc_ctrl_props (
  // clock and reset
  input wire logic                  i_clk,
  input wire logic                  i_arst_n,
  // watched ports
  input wire sac_pkg::sac_cpu_req_t i_cpu,
  input wire logic [7:0]            o_cpu_rdata,
  input wire logic [7:0]            i_analog_pin_select,
  input wire sac_pkg::sac_analog_t  o_analog,
  input wire logic [7:0]            o_port_digital_en,
  input wire logic                  o_conversion_done_irq,
  input wire logic [7:0]            o_conversion_result
);
  import sac_pkg::*;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  // channel field of the written byte
  logic [2:0] wr_ch;
  assign wr_ch = i_cpu.wdata[SAC_CH_MSB:SAC_CH_LSB];

  done_one_cycle_a : assert property (
    o_conversion_done_irq |=> !o_conversion_done_irq) else $error("done pulse wider than one cycle");
  result_hold_a : assert property (
    !o_conversion_done_irq |-> $stable(o_conversion_result)) else $error("result changed without done");
  port_enable_a : assert property (
    o_port_digital_en == ~i_analog_pin_select) else $error("digital enable not inverse of pin select");
  hold_release_a : assert property (
    $fell(o_analog.hold) |-> o_conversion_done_irq || $past(i_cpu.wr || i_cpu.bit_wr))
    else $error("hold released in mid conversion");
  tap_msb_a : assert property (
    $rose(o_analog.hold) |-> o_analog.tap_code == 8'h80) else $error("first tap not msb");
  chan_write_a : assert property (
    i_cpu.wr && i_cpu.addr == SAC_MODE_ADDR |=> o_analog.channel == $past(wr_ch))
    else $error("channel does not follow mode write");
  mode_readback_a : assert property (
    (i_cpu.wr && i_cpu.addr == SAC_MODE_ADDR) ##2 (i_cpu.rd && i_cpu.addr == SAC_MODE_ADDR && !i_cpu.wr)
    |=> o_cpu_rdata == $past(i_cpu.wdata, 3)) else $error("mode readback wrong");
  result_read_a : assert property (
    i_cpu.rd && i_cpu.addr == SAC_RESULT_ADDR |=> o_cpu_rdata == $past(o_conversion_result))
    else $error("result read wrong");
endmodule

bind sac_adc_ctrl sac_adc_ctrl_props sac_adc_ctrl_props_i (.i_clk, .i_arst_n, .i_cpu, .o_cpu_rdata,
  .i_analog_pin_select, .o_analog, .o_port_digital_en, .o_conversion_done_irq, .o_conversion_result);

// ==== sim/sac_analog_model.sv ====
`timescale 1ns/1ps

// sample-hold, ladder and comparator seen from the control block
module sac_analog_model (
  // clock
  input  wire logic                 i_clk,
  // control from the block, channel voltages as codes
  input  wire sac_pkg::sac_analog_t i_analog,
  input  wire logic [63:0]          i_vin,
  // comparator pin
  output logic                      o_comp
);
  import sac_pkg::*;
  logic [7:0] held_r;
  // track the chosen input while sampling, freeze while held
  always_ff @(posedge i_clk)
    if (!i_analog.hold)
      held_r <= i_vin[i_analog.channel*8 +: 8];
  // input at or above the ladder tap
  assign o_comp = held_r >= i_analog.tap_code;
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/1ps

module tb;
  import sac_pkg::*;
  typedef struct packed {
    logic [2:0] ch;
    logic [2:0] ts;
    logic       undiv;
    logic [8:0] len;
  } sac_row_t;
  logic         clk;
  logic         arst_n;
  sac_cpu_req_t cpu;
  logic [7:0]   rdata;
  logic [7:0]   pin_sel;
  logic [7:0]   port_en;
  logic [7:0]   result;
  logic [7:0]   v;
  logic         div_sel;
  logic         comp;
  logic         trig;
  logic         done;
  sac_analog_t  ana;
  logic [63:0]  vin;
  int           n;
  int           n_fail;
  int           samples_checked;
  // channel, time code, clock undivided, expected length
  sac_row_t rows [8] = '{'{3'h0, 3'h1, 1'b1, 9'h050}, '{3'h1, 3'h3, 1'b1, 9'h028},
    '{3'h2, 3'h4, 1'b1, 9'h032}, '{3'h3, 3'h5, 1'b1, 9'h064}, '{3'h4, 3'h1, 1'b0, 9'h0a0},
    '{3'h5, 3'h3, 1'b0, 9'h050}, '{3'h6, 3'h4, 1'b0, 9'h064}, '{3'h7, 3'h5, 1'b0, 9'h0c8}};

  sac_adc_ctrl sac_adc_ctrl_i (.i_clk(clk), .i_arst_n(arst_n), .i_cpu(cpu), .o_cpu_rdata(rdata),
    .i_main_clock_div_select(div_sel), .i_analog_pin_select(pin_sel), .i_comparator(comp),
    .i_ext_trigger_input(trig), .o_analog(ana), .o_port_digital_en(port_en),
    .o_conversion_done_irq(done), .o_conversion_result(result));
  sac_analog_model sac_analog_model_i (.i_clk(clk), .i_analog(ana), .i_vin(vin), .o_comp(comp));

  // clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one cpu access, then an idle cycle
  task automatic bus(input logic r, w, b, input logic [2:0] sel, input logic val,
                     input logic [15:0] a, input logic [7:0] d);
    cpu = {r, w, b, sel, val, a, d};
    @(negedge clk);
    cpu = '0;
    @(negedge clk);
  endtask

  // cycles until done is seen, stops at lim
  task automatic wait_done(input int lim);
    n = 0;
    while (done !== 1'b1 && n < lim)
    begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    final_report();
  end

  initial
  begin
    arst_n = 1'b0;
    cpu = '0;
    div_sel = 1'b1;
    pin_sel = 8'h00;
    trig = 1'b0;
    vin = 64'hffc3805a3c01a500;
    n_fail = 0;
    samples_checked = 0;
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    bus(1, 0, 0, 3'h0, 0, SAC_MODE_ADDR, 8'h00);
    chk("mode_reset", 9'h001, {1'b0, rdata});
    // every channel and time code, software repeat
    foreach (rows[i])
    begin
      div_sel = rows[i].undiv;
      pin_sel = 8'h01 << rows[i].ch;
      bus(0, 1, 0, 3'h0, 0, SAC_MODE_ADDR, {2'b10, rows[i].ts[2:1], rows[i].ch, rows[i].ts[0]});
      wait_done(300);
      @(negedge clk);
      wait_done(300);
      chk("conv_len", rows[i].len, 9'(n + 1));
      chk("result", {1'b0, vin[rows[i].ch*8 +: 8]}, {1'b0, result});
      chk("port_en", {1'b0, ~pin_sel}, {1'b0, port_en});
      @(negedge clk);
    end
    $display("test rows done");
    // stop in mid conversion, result read only, unmapped read
    div_sel = 1'b1;
    bus(0, 1, 0, 3'h0, 0, SAC_MODE_ADDR, 8'h91);
    repeat (20) @(negedge clk);
    bus(0, 1, 0, 3'h0, 0, SAC_MODE_ADDR, 8'h11);
    bus(1, 0, 0, 3'h0, 0, SAC_MODE_ADDR, 8'h00);
    chk("mode_read", 9'h011, {1'b0, rdata});
    v = result;
    wait_done(300);
    chk("stopped", 9'h12c, 9'(n));
    bus(0, 1, 0, 3'h0, 0, SAC_RESULT_ADDR, ~v);
    bus(1, 0, 0, 3'h0, 0, SAC_RESULT_ADDR, 8'h00);
    chk("result_ro", {1'b0, v}, {1'b0, rdata});
    bus(1, 0, 0, 3'h0, 0, 16'hff82, 8'h00);
    chk("unmapped", 9'h000, {1'b0, rdata});
    $display("test stop done");
    // single-bit write of run
    chk("done_low", 9'h000, {8'h00, done});
    bus(0, 0, 1, 3'h7, 1, SAC_MODE_ADDR, 8'h00);
    wait_done(100);
    chk("bit_start", 9'h001, {8'h00, n < 100});
    bus(1, 0, 0, 3'h0, 0, SAC_MODE_ADDR, 8'h00);
    chk("bit_mode", 9'h091, {1'b0, rdata});
    $display("test bit write done");
    // trigger start, input change while held, one shot
    vin[7:0] = 8'h6e;
    bus(0, 1, 0, 3'h0, 0, SAC_MODE_ADDR, 8'hd1);
    wait_done(100);
    chk("trig_idle", 9'h064, 9'(n));
    trig = 1'b1;
    repeat (20) @(negedge clk);
    vin[7:0] = 8'h11;
    wait_done(100);
    chk("trig_result", 9'h06e, {1'b0, result});
    trig = 1'b0;
    @(negedge clk);
    wait_done(200);
    chk("trig_once", 9'h0c8, 9'(n));
    $display("test trigger done");
    // reset in mid run keeps result, reloads mode
    bus(0, 1, 0, 3'h0, 0, SAC_MODE_ADDR, 8'h91);
    repeat (10) @(negedge clk);
    v = result;
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    chk("result_kept", {1'b0, v}, {1'b0, result});
    bus(1, 0, 0, 3'h0, 0, SAC_MODE_ADDR, 8'h00);
    chk("mode_rereset", 9'h001, {1'b0, rdata});
    $display("test reset done");
    final_report();
  end
endmodule
